// File: rslc_pkg.sv
// rslc_pkg: shared types and constants for the reset-source lock control
// assumes one 10 MHz core clock and a synchronous active-high reset
package rslc_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned LVD_SETTLE_NS = 200_000; // 0.2 ms settle, max
    localparam int unsigned LVD_SETTLE_CYC =
        (LVD_SETTLE_NS / 100 > 0) ? LVD_SETTLE_NS / 100 : 1;
    // undervoltage mode register layout
    localparam int unsigned UVM_ON_POS = 7;
    localparam int unsigned UVM_RSEL_POS = 1;
    localparam int unsigned UVM_FLAG_POS = 0;
    localparam logic [7:0] UVM_RSV_MASK = 8'h7C; // bits 2..6 reserved
    localparam logic [7:0] UVM_RST_VAL = 8'h00;
    localparam logic [7:0] LVL_RST_VAL = 8'h00;
    localparam logic DBG_SEL_RST_VAL = 1'b1;

    // software write strobes with data
    typedef struct packed {
        logic clk_watch_en_wr;
        logic clk_watch_en_val;
        logic osc_halt_wr;
        logic osc_halt_val;
        logic uvm_wr;
        logic [7:0] uvm_val;
        logic lvl_wr;
        logic [7:0] lvl_val;
        logic flags_wr;
        logic [2:0] flags_val;
        logic dbg_wr;
        logic dbg_val;
    } rslc_sw_t;

    // cause flags: bit0 clock watch, bit1 undervoltage, bit2 other reset request
    typedef struct packed {
        logic other;
        logic uv;
        logic clk_watch;
    } rslc_cause_t;

    typedef enum logic [1:0] {UV_OFF, UV_SETTLE, UV_READY} rslc_uv_st_t;
endpackage

// File: rslc_sync.sv
// rslc_sync: two-flop synchroniser for pin and analog level inputs
// assumes the input may change at any time relative to core_clk
`timescale 1ns/10ps
module rslc_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage read only by second stage
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// File: rslc_top.sv
// rslc_top: clock-watch lock, ring oscillator halt, undervoltage
// detector control, reset cause flags and debug mode select
// assumes software strobes are on core_clk; pins arrive asynchronously
// Contract
// (RL1) clock-watch enable, once set, ignores clears until reset
// (RL2) clock-watch reset clears enable and sets its cause flag
// (RL3) oscillator halts only if option allows and halt bit set
// (RL4) clock watch is inactive while oscillator is halted
// (RL5) software waits up to 0.2 ms before trusting undervoltage flag
// (RL6) interrupt follows flag only when detector on and reset-select 0
// (RL7) software writes zeros to mode register bits 2 to 6
// (RL8) detector on with reset-select locks detector until other reset
// (RL9) same lock blocks level-select writes until other reset
// (RL10) pin reset initialises debug select; debug entered on pin high
// (RL11) part of RAM not kept after power-on reset
// (RL12) cause flags clear by writing 0; set beats clear
// (RL13) with reset-select, undervoltage issues reset and records cause
`timescale 1ns/10ps
module rslc_top
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic power_on_rst,
    input wire logic osc_halt_allowed,
    input wire logic clk_fail,
    input wire logic uv_detect,
    input wire logic debug_reset_pin,
    input wire logic other_rst_req,
    input wire rslc_pkg::rslc_sw_t sw,
    output logic clock_watch_enable,
    output logic ring_osc_halt,
    output logic ring_osc_stopped,
    output logic clock_watch_active,
    output logic [7:0] undervoltage_mode_reg,
    output logic [7:0] detect_level_select,
    output logic undervoltage_irq,
    output logic uv_settled,
    output rslc_pkg::rslc_cause_t reset_cause_flags,
    output logic internal_rst_req,
    output logic debug_mode_select_bit,
    output logic debug_mode_entered,
    output logic ram_scrub_req
);
    import rslc_pkg::*;

    logic [3:0] pins_s;
    logic rst_pin_n_s;
    logic clk_fail_s;
    logic uv_s;
    logic dbg_pin_s;

    // pins pass two flops before use; reset pin enters inverted so the
    // cleared synchroniser reads as idle and fakes no reset after sys_rst
    rslc_sync #(.W(4)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({~reset_pin_n, clk_fail, uv_detect, debug_reset_pin}),
        .sync_out(pins_s)
    );
    assign rst_pin_n_s = ~pins_s[3];
    assign clk_fail_s = pins_s[2];
    assign uv_s = pins_s[1];
    assign dbg_pin_s = pins_s[0];

    logic cw_en_r, cw_en_nxt;
    logic halt_r, halt_nxt;
    logic [7:0] uvm_r, uvm_nxt;
    logic [7:0] lvl_r, lvl_nxt;
    rslc_cause_t cause_r, cause_nxt;
    logic dbg_sel_r, dbg_sel_nxt;
    logic dbg_on_r, dbg_on_nxt;
    logic ram_r, ram_nxt;
    rslc_uv_st_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic cw_rst, uv_rst, oth_rst, lock, osc_stop;

    // reset events and the undervoltage lock
    assign osc_stop = halt_r & osc_halt_allowed; // RL3
    assign cw_rst = cw_en_r & ~osc_stop & clk_fail_s; // RL4
    assign lock = uvm_r[UVM_ON_POS] & uvm_r[UVM_RSEL_POS]; // RL8
    assign uv_rst = lock & uv_s; // RL13
    assign oth_rst = other_rst_req | ~rst_pin_n_s | power_on_rst;

    // next values of control registers
    always_comb
    begin
        cw_en_nxt = cw_en_r
            | (sw.clk_watch_en_wr & sw.clk_watch_en_val); // RL1
        if (cw_rst | oth_rst | uv_rst)
            cw_en_nxt = 1'b0; // RL2
        halt_nxt = sw.osc_halt_wr ? sw.osc_halt_val : halt_r;
        uvm_nxt = uvm_r;
        if (sw.uvm_wr & ~lock) // RL8
            uvm_nxt = (sw.uvm_val & ~UVM_RSV_MASK) & 8'hFE; // RL7
        uvm_nxt[UVM_FLAG_POS] = uvm_r[UVM_ON_POS] & uv_s;
        lvl_nxt = (sw.lvl_wr & ~lock) ? sw.lvl_val : lvl_r; // RL9
        cause_nxt = cause_r;
        if (sw.flags_wr)
            cause_nxt = cause_r & sw.flags_val; // RL12
        cause_nxt.clk_watch = cause_nxt.clk_watch | cw_rst; // RL2
        cause_nxt.uv = cause_nxt.uv | uv_rst; // RL13
        cause_nxt.other = cause_nxt.other | other_rst_req; // RL12
        if (oth_rst)
        begin
            uvm_nxt = UVM_RST_VAL; // RL8
            lvl_nxt = LVL_RST_VAL;
            halt_nxt = 1'b0;
        end
        dbg_sel_nxt = (sw.dbg_wr ? sw.dbg_val : dbg_sel_r);
        dbg_on_nxt = dbg_on_r | (dbg_sel_r & dbg_pin_s); // RL10
        if (~rst_pin_n_s)
        begin
            dbg_sel_nxt = DBG_SEL_RST_VAL; // RL10
            dbg_on_nxt = 1'b0;
        end
        ram_nxt = power_on_rst; // RL11
    end

    // settle timer after detector turn-on
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            UV_OFF:
                if (uvm_r[UVM_ON_POS])
                begin
                    st_nxt = UV_SETTLE;
                    cnt_nxt = 16'(LVD_SETTLE_CYC - 1);
                end
            UV_SETTLE:
                if (!uvm_r[UVM_ON_POS])
                    st_nxt = UV_OFF;
                else if (cnt_r == 16'h0000)
                    st_nxt = UV_READY; // RL5
                else
                    cnt_nxt = cnt_r - 16'h0001;
            UV_READY:
                if (!uvm_r[UVM_ON_POS])
                    st_nxt = UV_OFF;
        endcase
    end

    // register all state
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cw_en_r <= 1'b0;
            halt_r <= 1'b0;
            uvm_r <= UVM_RST_VAL;
            lvl_r <= LVL_RST_VAL;
            cause_r <= '0;
            dbg_sel_r <= DBG_SEL_RST_VAL;
            dbg_on_r <= 1'b0;
            ram_r <= 1'b0;
            st_r <= UV_OFF;
            cnt_r <= 16'h0000;
        end
        else
        begin
            cw_en_r <= cw_en_nxt;
            halt_r <= halt_nxt;
            uvm_r <= uvm_nxt;
            lvl_r <= lvl_nxt;
            cause_r <= cause_nxt;
            dbg_sel_r <= dbg_sel_nxt;
            dbg_on_r <= dbg_on_nxt;
            ram_r <= ram_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // outputs
    assign clock_watch_enable = cw_en_r;
    assign ring_osc_halt = halt_r;
    assign ring_osc_stopped = osc_stop; // RL3
    assign clock_watch_active = cw_en_r & ~osc_stop; // RL4
    assign undervoltage_mode_reg = uvm_r;
    assign detect_level_select = lvl_r;
    assign undervoltage_irq = uvm_r[UVM_ON_POS] & ~uvm_r[UVM_RSEL_POS]
        & uvm_r[UVM_FLAG_POS]; // RL6
    assign uv_settled = (st_r == UV_READY);
    assign reset_cause_flags = cause_r;
    assign internal_rst_req = cw_rst | uv_rst; // RL13
    assign debug_mode_select_bit = dbg_sel_r;
    assign debug_mode_entered = dbg_on_r;
    assign ram_scrub_req = ram_r; // RL11

    // checks
    AST_LOCK_HOLDS: assert property ( // RL1
        @(posedge core_clk) disable iff (sys_rst)
        cw_en_r && !cw_rst && !oth_rst && !uv_rst |=> cw_en_r)
        else $error("clock watch enable cleared without reset");
    AST_CW_RESET: assert property ( // RL2
        @(posedge core_clk) disable iff (sys_rst)
        cw_rst |=> !cw_en_r && cause_r.clk_watch)
        else $error("clock watch reset not recorded");
    AST_HALT: assert property ( // RL3
        @(posedge core_clk) disable iff (sys_rst)
        ring_osc_stopped |-> halt_r && osc_halt_allowed)
        else $error("oscillator stopped without permission");
    AST_NO_CW_HALTED: assert property ( // RL4
        @(posedge core_clk) disable iff (sys_rst)
        osc_stop |-> !cw_rst)
        else $error("clock watch reset while oscillator halted");
    AST_IRQ: assert property ( // RL6
        @(posedge core_clk) disable iff (sys_rst)
        undervoltage_irq |-> !uvm_r[UVM_RSEL_POS] && uvm_r[UVM_ON_POS])
        else $error("undervoltage irq while not allowed");
    AST_LVL_LOCK: assert property ( // RL9
        @(posedge core_clk) disable iff (sys_rst)
        lock && !oth_rst |=> $stable(lvl_r))
        else $error("level select changed while locked");
    AST_UV_LOCK: assert property ( // RL8
        @(posedge core_clk) disable iff (sys_rst)
        lock && !oth_rst |=> uvm_r[UVM_ON_POS])
        else $error("detector stopped while locked");
    AST_SET_WINS: assert property ( // RL12
        @(posedge core_clk) disable iff (sys_rst)
        uv_rst |=> cause_r.uv)
        else $error("undervoltage cause lost");

    // locked detection with reset request in the same cycle, then cause recorded
    sequence s_uv_seen;
        lock && uv_s;
    endsequence
    sequence s_uv_recorded;
        internal_rst_req ##1 (cause_r.uv && !cw_en_r);
    endsequence
    AST_UV_RESET: assert property ( // RL13
        @(posedge core_clk) disable iff (sys_rst)
        s_uv_seen |-> s_uv_recorded)
        else $error("undervoltage reset not issued or not recorded");
endmodule

// File: rslc_top_tb.sv
// rslc_top_tb: self-checking bench for rslc_top against a small model
// assumes rslc_pkg and rslc_top are compiled first
`timescale 1ns/10ps
module rslc_top_tb;
    import rslc_pkg::*;
    logic core_clk = 0, sys_rst = 1, reset_pin_n = 1, power_on_rst = 0;
    logic osc_halt_allowed = 0, clk_fail = 0, uv_detect = 0;
    logic debug_reset_pin = 0, other_rst_req = 0;
    rslc_sw_t sw = '0;
    logic clock_watch_enable, ring_osc_halt, ring_osc_stopped;
    logic clock_watch_active, undervoltage_irq, uv_settled, internal_rst_req;
    logic debug_mode_select_bit, debug_mode_entered, ram_scrub_req;
    logic [7:0] undervoltage_mode_reg, detect_level_select, r;
    rslc_cause_t reset_cause_flags;
    int miscompares, compares, i, seed = 1;
    int m_en = 0, m_halt = 0, m_uvm = 0, m_lvl = 0, m_flg = 0, m_dbg = 1;

    rslc_top i_dut (.core_clk, .sys_rst, .reset_pin_n, .power_on_rst,
        .osc_halt_allowed, .clk_fail, .uv_detect, .debug_reset_pin,
        .other_rst_req, .sw, .clock_watch_enable, .ring_osc_halt,
        .ring_osc_stopped, .clock_watch_active, .undervoltage_mode_reg,
        .detect_level_select, .undervoltage_irq, .uv_settled,
        .reset_cause_flags, .internal_rst_req, .debug_mode_select_bit,
        .debug_mode_entered, .ram_scrub_req);

    // 100 ns core clock
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end

    // one-hot write strobe k, data v copied into every field
    function automatic rslc_sw_t mk(input int k, input logic [7:0] v);
        logic [5:0] m;
        m = 6'h20 >> k;
        return {m[5], v[0], m[4], v[0], m[3], v, m[2], v, m[1], v[2:0],
            m[0], v[0]};
    endfunction

    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task give_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // bounded wait ran out
    task tmo(input logic ok);
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("mismatch wait expected 1 seen %b", ok);
            give_verdict();
        end
    endtask

    task cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task chkall;
        chk("enable", clock_watch_enable, 8'(m_en));
        chk("halt", ring_osc_halt, 8'(m_halt));
        chk("mode", undervoltage_mode_reg, 8'(m_uvm));
        chk("level", detect_level_select, 8'(m_lvl));
        chk("flags", {5'h0, reset_cause_flags}, 8'(m_flg));
        chk("dbgsel", debug_mode_select_bit, 8'(m_dbg));
    endtask

    // one-cycle write strobe, then model update and full compare
    task wr(input int k, input logic [7:0] v);
        @(posedge core_clk);
        sw <= mk(k, v);
        @(posedge core_clk);
        sw <= '0;
        @(negedge core_clk);
        case (k)
            0: m_en = m_en | int'(v[0]);
            1: m_halt = int'(v[0]);
            2: if ((m_uvm & 130) != 130) m_uvm = int'(v & 8'h82);
            3: if ((m_uvm & 130) != 130) m_lvl = int'(v);
            4: m_flg = m_flg & int'(v);
            default: m_dbg = int'(v[0]);
        endcase
        chkall();
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        cyc(1);
        chkall();
        wr(0, 8'h01);
        wr(0, 8'h00);
        wr(1, 8'h01);
        chk("stopped", ring_osc_stopped, 8'h00);
        chk("active", clock_watch_active, 8'h01);
        @(posedge core_clk);
        osc_halt_allowed <= 1'b1;
        clk_fail <= 1'b1;
        cyc(8);
        chk("stopped", ring_osc_stopped, 8'h01);
        chk("active", clock_watch_active, 8'h00);
        chk("rstreq", internal_rst_req, 8'h00);
        @(posedge core_clk);
        osc_halt_allowed <= 1'b0;
        for (i = 0; i < 20 && reset_cause_flags.clk_watch !== 1'b1; i++)
            cyc(1);
        tmo(reset_cause_flags.clk_watch);
        @(posedge core_clk);
        clk_fail <= 1'b0;
        m_en = 0;
        m_flg = 1;
        wr(1, 8'h00);
        $display("test clock watch done");
        wr(4, 8'h06);
        @(posedge core_clk);
        other_rst_req <= 1'b1;
        sw <= mk(4, 8'h00);
        @(posedge core_clk);
        other_rst_req <= 1'b0;
        sw <= '0;
        cyc(2);
        m_flg = 4;
        chkall();
        wr(4, 8'h00);
        $display("test flags done");
        r = 8'($random(seed));
        wr(3, r);
        wr(2, 8'h80);
        chk("settled", uv_settled, 8'h00);
        for (i = 0; i < 2100 && uv_settled !== 1'b1; i++)
            cyc(1);
        tmo(uv_settled);
        chk("settle", 8'(i - LVD_SETTLE_CYC), 8'h01);
        @(posedge core_clk);
        uv_detect <= 1'b1;
        cyc(5);
        chk("irq", undervoltage_irq, 8'h01);
        chk("mode", undervoltage_mode_reg, 8'h81);
        @(posedge core_clk);
        uv_detect <= 1'b0;
        cyc(5);
        wr(2, 8'h83);
        wr(3, ~r);
        wr(2, 8'h00);
        @(posedge core_clk);
        uv_detect <= 1'b1;
        for (i = 0; i < 10 && internal_rst_req !== 1'b1; i++)
            cyc(1);
        tmo(internal_rst_req);
        chk("irq", undervoltage_irq, 8'h00);
        @(posedge core_clk);
        uv_detect <= 1'b0;
        cyc(5);
        m_flg = 2;
        chkall();
        $display("test undervoltage done");
        @(posedge core_clk);
        power_on_rst <= 1'b1;
        @(posedge core_clk);
        power_on_rst <= 1'b0;
        @(negedge core_clk);
        chk("scrub", ram_scrub_req, 8'h01);
        m_uvm = 0;
        m_lvl = 0;
        wr(4, 8'h00);
        wr(2, 8'h80);
        $display("test power on done");
        wr(5, 8'h00);
        @(posedge core_clk);
        debug_reset_pin <= 1'b1;
        cyc(5);
        chk("dbgent", debug_mode_entered, 8'h00);
        @(posedge core_clk);
        debug_reset_pin <= 1'b0;
        reset_pin_n <= 1'b0;
        cyc(4);
        @(posedge core_clk);
        reset_pin_n <= 1'b1;
        cyc(4);
        chk("dbgsel", debug_mode_select_bit, 8'h01);
        @(posedge core_clk);
        debug_reset_pin <= 1'b1;
        cyc(5);
        chk("dbgent", debug_mode_entered, 8'h01);
        $display("test debug done");
        give_verdict();
    end
endmodule
